// [hw/tcsr_consts.svh]
`ifndef TCSR_CONSTS_SVH
`define TCSR_CONSTS_SVH

// register offsets
`define TCSR_ADDR_CLK_SEL 8'h8E
`define TCSR_ADDR_T3_CTRL 8'h91
`define TCSR_ADDR_T3_RLD_LO 8'h92
`define TCSR_ADDR_T3_RLD_HI 8'h93
`define TCSR_ADDR_T3_CNT_LO 8'h94
`define TCSR_ADDR_T3_CNT_HI 8'h95
`define TCSR_ADDR_IRQ_EN1 8'hE6

// reset values
`define TCSR_RST_BYTE 8'h00

// clock-select fields
`define TCSR_CS_T3_HI 7
`define TCSR_CS_T3_LO 6
`define TCSR_CS_T2_HI 5
`define TCSR_CS_T2_LO 4
`define TCSR_CS_T1 3
`define TCSR_CS_T0 2
`define TCSR_CS_PRE_MSB 1
`define TCSR_CS_PRE_LSB 0

// prescale codes
`define TCSR_PRE_DIV12 2'h0
`define TCSR_PRE_DIV4 2'h1
`define TCSR_PRE_DIV48 2'h2
`define TCSR_PRE_EXT8 2'h3

// timer-3 control fields
`define TCSR_T3_HI_FLAG 7
`define TCSR_T3_LO_FLAG 6
`define TCSR_T3_LO_IRQ_EN 5
`define TCSR_T3_CAP_EN 4
`define TCSR_T3_SPLIT 3
`define TCSR_T3_RUN 2
`define TCSR_T3_CAP_SRC 1
`define TCSR_T3_EXT_CLK 0

// extended interrupt enable field
`define TCSR_IE1_T3 7

// division counts
`define TCSR_DIV_FAST 4
`define TCSR_DIV_MID 12
`define TCSR_DIV_SLOW 48

// count limits
`define TCSR_BYTE_MAX 8'hFF
`define TCSR_WORD_MAX 16'hFFFF

`endif

// [hw/tcsr_pkg.sv]
package tcsr_pkg;

  // gray order: 16-bit, split, lfo capture, sof capture
  typedef enum logic [1:0] {
    TCSR_AUTO16 = 2'h0,
    TCSR_SPLIT8 = 2'h1,
    TCSR_CAP_LFO = 2'h3,
    TCSR_CAP_SOF = 2'h2
  } tcsr_mode_t;

  typedef logic [7:0] tcsr_byte_t;

endpackage

// [hw/tcsr_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser with rising-edge pulse per bit
module tcsr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  if (WIDTH < 1) begin : g_chk
    $error("tcsr_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= async_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign rise_o = sync & ~prev;

endmodule

`default_nettype wire

// [hw/tcsr_presc.sv]
`timescale 1ns/1ps
`default_nettype none

// free-running system-clock dividers, one tick pulse each
module tcsr_presc #(
  parameter int unsigned DIV_FAST = 4,
  parameter int unsigned DIV_MID = 12,
  parameter int unsigned DIV_SLOW = 48
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [2:0] tick_o
);

  localparam int unsigned CW = $clog2(DIV_SLOW);
  localparam int unsigned DIVS [3] = '{DIV_FAST, DIV_MID, DIV_SLOW};

  if (DIV_FAST < 2 || DIV_MID < DIV_FAST || DIV_SLOW < DIV_MID) begin : g_chk
    $error("tcsr_presc: divisors must be at least 2 and ascending");
  end

  genvar g;
  for (g = 0; g < 3; g++) begin : g_div
    localparam logic [CW-1:0] TOP = CW'(DIVS[g] - 1);
    logic [CW-1:0] cnt;
    logic tick;
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        cnt <= '0;
        tick <= 1'b0;
      end else if (cnt == TOP) begin
        cnt <= '0;
        tick <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
        tick <= 1'b0;
      end
    end
    assign tick_o[g] = tick;
  end

endmodule

`default_nettype wire

// [hw/tcsr_top.sv]
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "tcsr_consts.svh"

module tcsr_top #(
  parameter int unsigned DIV_FAST = `TCSR_DIV_FAST,
  parameter int unsigned DIV_MID = `TCSR_DIV_MID,
  parameter int unsigned DIV_SLOW = `TCSR_DIV_SLOW
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // external sources
  input wire logic EXT_DIV8_I,
  input wire logic LOW_FREQ_OSC_I,
  input wire logic SOF_I,
  // settings owned by neighbouring timers
  input wire logic TIMER_ZERO_COUNTER_SEL_I,
  input wire logic TIMER_ONE_COUNTER_SEL_I,
  input wire logic T2_EXT_CLK_CHOICE_I,
  // clock ticks for neighbouring timers
  output logic T0_TICK_O,
  output logic T1_TICK_O,
  output logic T2_LO_TICK_O,
  output logic T2_HI_TICK_O,
  // timer-3 status
  output logic [15:0] T3_COUNT_O,
  output logic T3_IRQ_O
);

  // prescaler selection assumes ascending dividers
  if (DIV_FAST < 2 || DIV_MID < DIV_FAST || DIV_SLOW < DIV_MID) begin : g_chk
    $error("tcsr_top: divisors must be at least 2 and ascending");
  end

  // ---------------- registers ----------------
  tcsr_pkg::tcsr_byte_t timer_clock_select;
  tcsr_pkg::tcsr_byte_t t3_control;
  tcsr_pkg::tcsr_byte_t timer3_reload_low;
  tcsr_pkg::tcsr_byte_t timer3_reload_high;
  tcsr_pkg::tcsr_byte_t timer3_count_low;
  tcsr_pkg::tcsr_byte_t t3_count_high;
  tcsr_pkg::tcsr_byte_t ext_irq_enable_1;

  tcsr_pkg::tcsr_byte_t next_control;
  tcsr_pkg::tcsr_byte_t next_reload_low;
  tcsr_pkg::tcsr_byte_t next_reload_high;
  tcsr_pkg::tcsr_byte_t next_count_low;
  tcsr_pkg::tcsr_byte_t next_count_high;

  // ---------------- tick sources ----------------
  logic [2:0] sys_tick;
  logic [1:0] edge_pulse;
  wire logic ext8_tick;
  wire logic lfo_rise;

  tcsr_presc #(
    .DIV_FAST(DIV_FAST),
    .DIV_MID(DIV_MID),
    .DIV_SLOW(DIV_SLOW)
  ) u_presc (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .tick_o(sys_tick)
  );

  // external /8 clock and slow oscillator both cross in here
  tcsr_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .async_i({LOW_FREQ_OSC_I, EXT_DIV8_I}),
    .rise_o(edge_pulse)
  );

  assign ext8_tick = edge_pulse[0];
  assign lfo_rise = edge_pulse[1];

  wire logic tick_div4 = sys_tick[0];
  wire logic tick_div12 = sys_tick[1];
  wire logic tick_div48 = sys_tick[2];

  // ---------------- clock selection ----------------
  wire logic [1:0] t01_prescale = timer_clock_select[`TCSR_CS_PRE_MSB:`TCSR_CS_PRE_LSB];
  wire logic t3_hi_clk_sel = timer_clock_select[`TCSR_CS_T3_HI];
  wire logic t3_lo_clk_sel = timer_clock_select[`TCSR_CS_T3_LO];
  wire logic t2_hi_clk_sel = timer_clock_select[`TCSR_CS_T2_HI];
  wire logic t2_lo_clk_sel = timer_clock_select[`TCSR_CS_T2_LO];
  wire logic timer_one_clk_sel = timer_clock_select[`TCSR_CS_T1];
  wire logic timer_zero_clk_sel = timer_clock_select[`TCSR_CS_T0];

  wire logic prescale_tick =
    (t01_prescale == `TCSR_PRE_DIV12) ? tick_div12 :
    (t01_prescale == `TCSR_PRE_DIV4) ? tick_div4 :
    (t01_prescale == `TCSR_PRE_DIV48) ? tick_div48 : ext8_tick;

  // an event-counting timer takes its own pin, so no tick is offered
  wire logic t0_tick_sel = TIMER_ZERO_COUNTER_SEL_I ? 1'b0 :
    (timer_zero_clk_sel ? 1'b1 : prescale_tick);
  wire logic t1_tick_sel = TIMER_ONE_COUNTER_SEL_I ? 1'b0 :
    (timer_one_clk_sel ? 1'b1 : prescale_tick);

  wire logic t2_ext_tick = T2_EXT_CLK_CHOICE_I ? ext8_tick : tick_div12;
  wire logic t2_lo_tick_sel = t2_lo_clk_sel ? 1'b1 : t2_ext_tick;
  wire logic t2_hi_tick_sel = t2_hi_clk_sel ? 1'b1 : t2_ext_tick;

  wire logic t3_ext_clk_choice = t3_control[`TCSR_T3_EXT_CLK];
  wire logic t3_ext_tick = t3_ext_clk_choice ? ext8_tick : tick_div12;
  wire logic t3_lo_tick = t3_lo_clk_sel ? 1'b1 : t3_ext_tick;
  wire logic t3_hi_tick = t3_hi_clk_sel ? 1'b1 : t3_ext_tick;

  // ---------------- timer-3 mode ----------------
  wire logic t3_split_mode = t3_control[`TCSR_T3_SPLIT];
  wire logic t3_capture_enable = t3_control[`TCSR_T3_CAP_EN];
  wire logic t3_capture_source = t3_control[`TCSR_T3_CAP_SRC];
  wire logic t3_run = t3_control[`TCSR_T3_RUN];
  // enable as it will stand after this edge, so the request matches the stored bits
  wire logic t3_low_irq_enable = next_control[`TCSR_T3_LO_IRQ_EN];

  // capture has priority over split
  wire tcsr_pkg::tcsr_mode_t t3_mode =
    !t3_capture_enable ? (t3_split_mode ? tcsr_pkg::TCSR_SPLIT8 : tcsr_pkg::TCSR_AUTO16) :
    (t3_capture_source ? tcsr_pkg::TCSR_CAP_LFO : tcsr_pkg::TCSR_CAP_SOF);

  // ---------------- timer-3 counting ----------------
  wire logic [15:0] t3_count = {t3_count_high, timer3_count_low};
  wire logic [15:0] t3_reload = {timer3_reload_high, timer3_reload_low};
  wire logic [15:0] t3_count_inc = t3_count + 16'h0001;

  wire logic lo_at_max = timer3_count_low == `TCSR_BYTE_MAX;
  wire logic hi_at_max = t3_count_high == `TCSR_BYTE_MAX;
  wire logic word_at_max = t3_count == `TCSR_WORD_MAX;

  wire logic full_step = t3_run && t3_lo_tick;
  // split mode: low byte free-runs, run bit gates only the high byte
  wire logic split_lo_step = t3_lo_tick;
  wire logic split_hi_step = t3_run && t3_hi_tick;

  wire logic capture_evt = (t3_mode == tcsr_pkg::TCSR_CAP_SOF) ? SOF_I :
    (t3_mode == tcsr_pkg::TCSR_CAP_LFO) ? lfo_rise : 1'b0;

  // ---------------- register decode ----------------
  wire logic sel_clk = ADDR_I == `TCSR_ADDR_CLK_SEL;
  wire logic sel_ctrl = ADDR_I == `TCSR_ADDR_T3_CTRL;
  wire logic sel_rld_lo = ADDR_I == `TCSR_ADDR_T3_RLD_LO;
  wire logic sel_rld_hi = ADDR_I == `TCSR_ADDR_T3_RLD_HI;
  wire logic sel_cnt_lo = ADDR_I == `TCSR_ADDR_T3_CNT_LO;
  wire logic sel_cnt_hi = ADDR_I == `TCSR_ADDR_T3_CNT_HI;
  wire logic sel_ie1 = ADDR_I == `TCSR_ADDR_IRQ_EN1;

  wire logic wr_clk = WR_I && sel_clk;
  wire logic wr_ctrl = WR_I && sel_ctrl;
  wire logic wr_rld_lo = WR_I && sel_rld_lo;
  wire logic wr_rld_hi = WR_I && sel_rld_hi;
  wire logic wr_cnt_lo = WR_I && sel_cnt_lo;
  wire logic wr_cnt_hi = WR_I && sel_cnt_hi;
  wire logic wr_ie1 = WR_I && sel_ie1;

  // unmapped addresses read as zero
  wire tcsr_pkg::tcsr_byte_t read_mux =
    sel_clk ? timer_clock_select :
    sel_ctrl ? t3_control :
    sel_rld_lo ? timer3_reload_low :
    sel_rld_hi ? timer3_reload_high :
    sel_cnt_lo ? timer3_count_low :
    sel_cnt_hi ? t3_count_high :
    sel_ie1 ? ext_irq_enable_1 : `TCSR_RST_BYTE;

  // ---------------- next-state logic ----------------
  logic set_hi_flag;
  logic set_lo_flag;

  always_comb begin
    next_count_low = timer3_count_low;
    next_count_high = t3_count_high;
    next_reload_low = timer3_reload_low;
    next_reload_high = timer3_reload_high;
    set_hi_flag = 1'b0;
    set_lo_flag = 1'b0;
    unique case (t3_mode)
      tcsr_pkg::TCSR_AUTO16: begin
        if (full_step) begin
          if (word_at_max) begin
            {next_count_high, next_count_low} = t3_reload;
            set_hi_flag = 1'b1;
          end else begin
            {next_count_high, next_count_low} = t3_count_inc;
          end
          if (lo_at_max) begin
            set_lo_flag = 1'b1;
          end
        end
      end
      tcsr_pkg::TCSR_SPLIT8: begin
        if (split_lo_step) begin
          if (lo_at_max) begin
            next_count_low = timer3_reload_low;
            set_lo_flag = 1'b1;
          end else begin
            next_count_low = timer3_count_low + 8'h01;
          end
        end
        if (split_hi_step) begin
          if (hi_at_max) begin
            next_count_high = timer3_reload_high;
            set_hi_flag = 1'b1;
          end else begin
            next_count_high = t3_count_high + 8'h01;
          end
        end
      end
      tcsr_pkg::TCSR_CAP_SOF, tcsr_pkg::TCSR_CAP_LFO: begin
        // free-running count; events copy it into the reload pair
        if (full_step) begin
          {next_count_high, next_count_low} = t3_count_inc;
          if (word_at_max) begin
            set_hi_flag = 1'b1;
          end
          if (lo_at_max) begin
            set_lo_flag = 1'b1;
          end
        end
        if (capture_evt) begin
          {next_reload_high, next_reload_low} = t3_count;
          set_hi_flag = 1'b1;
        end
      end
    endcase
    // software count writes override hardware on the same byte
    if (wr_cnt_lo) begin
      next_count_low = WDATA_I;
    end
    if (wr_cnt_hi) begin
      next_count_high = WDATA_I;
    end
    // captured value wins over a simultaneous software write
    if (wr_rld_lo && !capture_evt) begin
      next_reload_low = WDATA_I;
    end
    if (wr_rld_hi && !capture_evt) begin
      next_reload_high = WDATA_I;
    end
  end

  // flags: software write sets the written value, a hardware set wins
  always_comb begin
    next_control = wr_ctrl ? WDATA_I : t3_control;
    if (set_hi_flag) begin
      next_control[`TCSR_T3_HI_FLAG] = 1'b1;
    end
    if (set_lo_flag) begin
      next_control[`TCSR_T3_LO_FLAG] = 1'b1;
    end
  end

  // request follows the register values being stored at this edge
  wire logic t3_irq_enable = wr_ie1 ? WDATA_I[`TCSR_IE1_T3] :
    ext_irq_enable_1[`TCSR_IE1_T3];
  wire logic next_irq = t3_irq_enable &&
    (next_control[`TCSR_T3_HI_FLAG] ||
     (t3_low_irq_enable && next_control[`TCSR_T3_LO_FLAG]));

  // ---------------- storage ----------------
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      timer_clock_select <= `TCSR_RST_BYTE;
      ext_irq_enable_1 <= `TCSR_RST_BYTE;
    end else begin
      if (wr_clk) begin
        timer_clock_select <= WDATA_I;
      end
      // only bit 7 is used here, the rest is plain storage
      if (wr_ie1) begin
        ext_irq_enable_1 <= WDATA_I;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      t3_control <= `TCSR_RST_BYTE;
      timer3_reload_low <= `TCSR_RST_BYTE;
      timer3_reload_high <= `TCSR_RST_BYTE;
      timer3_count_low <= `TCSR_RST_BYTE;
      t3_count_high <= `TCSR_RST_BYTE;
    end else begin
      t3_control <= next_control;
      timer3_reload_low <= next_reload_low;
      timer3_reload_high <= next_reload_high;
      timer3_count_low <= next_count_low;
      t3_count_high <= next_count_high;
    end
  end

  // ---------------- outputs ----------------
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= `TCSR_RST_BYTE;
      T0_TICK_O <= 1'b0;
      T1_TICK_O <= 1'b0;
      T2_LO_TICK_O <= 1'b0;
      T2_HI_TICK_O <= 1'b0;
      T3_IRQ_O <= 1'b0;
      T3_COUNT_O <= 16'h0000;
    end else begin
      RDATA_O <= RD_I ? read_mux : `TCSR_RST_BYTE;
      T0_TICK_O <= t0_tick_sel;
      T1_TICK_O <= t1_tick_sel;
      T2_LO_TICK_O <= t2_lo_tick_sel;
      T2_HI_TICK_O <= t2_hi_tick_sel;
      T3_IRQ_O <= next_irq;
      T3_COUNT_O <= {next_count_high, next_count_low};
    end
  end

endmodule

`default_nettype wire

// [test/tcsr_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module tcsr_top_props #(
  parameter int unsigned DIV_FAST = 4
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // register port
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  // timer side
  input wire logic TIMER_ZERO_COUNTER_SEL_I,
  input wire logic T0_TICK_O,
  input wire logic [15:0] T3_COUNT_O,
  input wire logic T3_IRQ_O
);
  logic [7:0] cs;
  logic [2:0] ctl;
  logic [15:0] rld;
  logic ie7;
  logic go;
  logic [3:0] stab;
  wire wr_cs = WR_I && ADDR_I == 8'h8E;
  // capture off, split off, run on
  wire run16 = ctl == 3'h1;
  // 16-bit mode on system clock for two cycles, no write pending
  wire live = go && run16 && cs[6] && !WR_I;
  wire zsel = TIMER_ZERO_COUNTER_SEL_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cs <= 8'h00;
      ctl <= 3'h0;
      rld <= 16'h0000;
      ie7 <= 1'b0;
      go <= 1'b0;
      stab <= 4'h0;
    end else begin
      if (wr_cs) cs <= WDATA_I;
      if (WR_I && ADDR_I == 8'h91) ctl <= WDATA_I[4:2];
      if (WR_I && ADDR_I == 8'h92) rld[7:0] <= WDATA_I;
      if (WR_I && ADDR_I == 8'h93) rld[15:8] <= WDATA_I;
      if (WR_I && ADDR_I == 8'hE6) ie7 <= WDATA_I[7];
      go <= run16 && cs[6];
      stab <= wr_cs ? 4'h0 : stab + 4'(stab != 4'hF);
    end
  end
  chk_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside its slot");
  chk_t0_forced: assert property (zsel && $past(zsel) |-> !T0_TICK_O)
    else $error("timer 0 tick while counting events");
  chk_t0_system_clock: assert property (cs[2] && $past(cs[2]) && !zsel && !$past(zsel)
    |-> T0_TICK_O) else $error("timer 0 tick low on system clock");
  chk_div4_gap: assert property (stab > 4'h6 && cs[2:0] == 3'h1 && !zsel && T0_TICK_O
    |-> $past(T0_TICK_O, DIV_FAST) && !$past(T0_TICK_O)) else $error("prescale by 4 spacing");
  chk_t3_step: assert property (live && T3_COUNT_O != 16'hFFFF
    |=> T3_COUNT_O == $past(T3_COUNT_O) + 16'h0001) else $error("timer 3 did not step");
  chk_t3_reload: assert property (live && T3_COUNT_O == 16'hFFFF |=> T3_COUNT_O == rld)
    else $error("timer 3 reload value wrong");
  chk_ovf_irq: assert property (live && ie7 && T3_COUNT_O == 16'hFFFF ##1 1'b1
    |-> T3_IRQ_O) else $error("overflow raised no request");
  chk_irq_masked: assert property (!ie7 && !$past(ie7) |-> !T3_IRQ_O)
    else $error("request while disabled");
  chk_irq_sticky: assert property (T3_IRQ_O && !WR_I |=> T3_IRQ_O)
    else $error("request dropped without a write");
  chk_t3_hold: assert property (ctl == 3'h0 && $past(ctl) == 3'h0 && !WR_I
    |=> $stable(T3_COUNT_O)) else $error("stopped timer 3 moved");
endmodule

bind tcsr_top tcsr_top_props #(.DIV_FAST(DIV_FAST)) u_props (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .TIMER_ZERO_COUNTER_SEL_I(TIMER_ZERO_COUNTER_SEL_I), .T0_TICK_O(T0_TICK_O),
  .T3_COUNT_O(T3_COUNT_O), .T3_IRQ_O(T3_IRQ_O)
);
`default_nettype wire

// [test/tcsr_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tcsr_top_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext = 1'b0;
  logic zsel = 1'b0;
  logic t2ch = 1'b0;
  logic sof = 1'b0;
  logic low_freq_osc = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rdata;
  logic [15:0] cnt;
  logic t0, t1, t2l, t2h, irq;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic [7:0] regs[9] = '{8'h8E, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'hE6, 8'h90, 8'h8F};
  logic [7:0] v[6];
  logic [15:0] n[4];
  int e0[6] = '{12, 60, 5, 12, 240, 0};
  int e2[6] = '{20, 20, 20, 12, 240, 240};
  integer seed = 32'hF0589C2A;
  int errors = 0;
  int n_compared = 0;

  tcsr_top DUT (
    .CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .EXT_DIV8_I(ext), .LOW_FREQ_OSC_I(low_freq_osc), .SOF_I(sof),
    .TIMER_ZERO_COUNTER_SEL_I(zsel), .TIMER_ONE_COUNTER_SEL_I(zsel),
    .T2_EXT_CLK_CHOICE_I(t2ch), .T0_TICK_O(t0), .T1_TICK_O(t1), .T2_LO_TICK_O(t2l),
    .T2_HI_TICK_O(t2h), .T3_COUNT_O(cnt), .T3_IRQ_O(irq)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic results;
    $display("errors %0d of %0d compared", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t read %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_n(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t port %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd8(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_n({15'h0, irq}, {15'h0, e});
  endtask

  // read data checker
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q) cmp_rd(rdata & msk_q.pop_front(), exp_q.pop_front());
  end

  initial begin
    #200000;
    errors++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) rd8(regs[i], 8'h00, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      v[i] = 8'($random(seed));
      if (i != 1) wr8(regs[i], v[i]);
    end
    wr8(8'h90, 8'h5A);
    for (int i = 0; i < 6; i++) begin
      if (i != 1) rd8(regs[i], v[i], 8'hFF);
    end
    rd8(8'h90, 8'h00, 8'hFF);
    @(negedge clk);
    cmp_n(cnt, {v[5], v[4]});
    // tick counts over a 240-cycle window per clock choice
    for (int k = 0; k < 6; k++) begin
      wr8(8'h8E, (k < 4) ? 8'(k) : 8'h3C);
      zsel <= (k == 5);
      t2ch <= (k == 3);
      repeat (8) @(posedge clk);
      n = '{default: 16'h0000};
      for (int i = 1; i <= 240; i++) begin
        @(posedge clk);
        if (i % 10 == 0) ext <= ~ext;
        @(negedge clk);
        n[0] += 16'(t0 === 1'b1);
        n[1] += 16'(t1 === 1'b1);
        n[2] += 16'(t2l === 1'b1);
        n[3] += 16'(t2h === 1'b1);
      end
      cmp_n(n[0], 16'(e0[k] == 12 && k == 0 ? 20 : e0[k]));
      cmp_n(n[1], 16'(k == 0 ? 20 : e0[k]));
      cmp_n(n[2], 16'(e2[k]));
      cmp_n(n[3], 16'(e2[k]));
    end
    // timer 3 from one below overflow, request masked first
    wr8(8'h8E, 8'h40);
    wr8(8'hE6, 8'h00);
    wr8(8'h92, 8'hFE);
    wr8(8'h93, 8'hFF);
    wr8(8'h94, 8'hFE);
    wr8(8'h95, 8'hFF);
    wr8(8'h91, 8'h04);
    repeat (4) @(posedge clk);
    rd8(8'h91, 8'h84, 8'hBF);
    irq_is(1'b0);
    wr8(8'hE6, 8'h80);
    irq_is(1'b1);
    wr8(8'h91, 8'h80);
    wr8(8'h92, 8'h00);
    irq_is(1'b1);
    wr8(8'h91, 8'h00);
    irq_is(1'b0);
    // low byte rollover with its own enable
    wr8(8'h93, 8'h00);
    wr8(8'h94, 8'hFE);
    wr8(8'h95, 8'h00);
    wr8(8'h91, 8'h24);
    irq_is(1'b1);
    rd8(8'h91, 8'h64, 8'hFF);
    wr8(8'h91, 8'h00);
    irq_is(1'b0);
    // capture on start-of-frame, then on a slow-oscillator rise with the count frozen
    wr8(8'h94, 8'h10);
    wr8(8'h95, 8'h20);
    wr8(8'h91, 8'h14);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
    rd8(8'h92, 8'h10, 8'hFF);
    rd8(8'h93, 8'h20, 8'hFF);
    rd8(8'h91, 8'h94, 8'hFF);
    irq_is(1'b1);
    wr8(8'h91, 8'h12);
    wr8(8'h94, 8'h34);
    wr8(8'h95, 8'h12);
    low_freq_osc <= 1'b1;
    repeat (4) @(posedge clk);
    rd8(8'h92, 8'h34, 8'hFF);
    rd8(8'h93, 8'h12, 8'hFF);
    rd8(8'h91, 8'h92, 8'hFF);
    repeat (4) @(posedge clk);
    results();
  end
endmodule
`default_nettype wire
